// file: logic/dsp_dec_pkg.sv
// constants, types and decode tables for the signal-processing extension decoder
// Summary of operation
// - major opcode from bits 31..26, row/column
// - major 011111 selects extended op space
// - branch rt 11100 position branch, 11101 reserved
// - function bits 5..0 select extension classes
// - higher-level function codes raise reserved exception
// - reserved codes, upper 011/101, raise exception
// - release 1 traps whole extended space
// - op field bits 10..6, operand fields fixed
// - add/subtract op codes map to operations
// - unassigned add/subtract ops: implementation choice
// - compare/pick op codes map, others reserved
// - op 01001 halfword absolute, bits 25..21 zero
// - op 01010 replicate, 10-bit immediate 25..16
// - indexed load uses base and index fields
// - dot product accumulator from bits 12..11
// - accumulator moves use bits 12..11 or 22..21
package dsp_dec_pkg;

	// instruction field positions
	localparam int MAJOR_HI = 31;                  // major opcode msb
	localparam int MAJOR_LO = 26;                  // major opcode lsb
	localparam int FIRST_HI = 25;                  // first source field
	localparam int FIRST_LO = 21;
	localparam int SECOND_HI = 20;                 // second source field
	localparam int SECOND_LO = 16;
	localparam int DEST_HI = 15;                   // destination field
	localparam int DEST_LO = 11;
	localparam int SUBOP_HI = 10;                  // sub operation field
	localparam int SUBOP_LO = 6;
	localparam int FUNC_HI = 5;                    // function field
	localparam int FUNC_LO = 0;
	localparam int ACC_TO_LO = 11;                 // accumulator for moves into / dot product
	localparam int ACC_FROM_LO = 21;               // accumulator for moves out

	// major opcodes
	localparam logic [5:0] MAJOR_EXTENDED = 6'h1F; // extended op space
	localparam logic [5:0] MAJOR_BRANCH = 6'h01;   // immediate branch class
	localparam logic [5:0] MAJOR_BASE_DEF = 6'h00; // base space holding accumulator moves

	// immediate branch second source codes
	localparam logic [4:0] RT_POS_GE_32 = 5'h1C;   // branch if position >= 32
	localparam logic [4:0] RT_POS_HIGHER = 5'h1D;  // higher ISA level

	// function codes in the extended op space
	localparam logic [5:0] FN_INDEXED_LOAD = 6'h0A;
	localparam logic [5:0] FN_INSERT_VAR = 6'h0C;
	localparam logic [5:0] FN_ADD_SUB = 6'h10;
	localparam logic [5:0] FN_CMP_PICK = 6'h11;
	localparam logic [5:0] FN_ABS_REPL = 6'h12;
	localparam logic [5:0] FN_SHIFT = 6'h13;
	localparam logic [5:0] FN_DOT_PROD = 6'h30;
	localparam logic [5:0] FN_ACC_EXTRACT = 6'h38;

	// function codes that are explicitly reserved, one bit per code
	localparam logic [63:0] FN_RESERVED_MAP = 64'hF6FE_FFEE_FFFF_E800;

	// sub operation codes named by the absolute/replicate class
	localparam logic [4:0] OP_ABS_HALF = 5'h09;
	localparam logic [4:0] OP_REPL_HALF = 5'h0A;

	// legal sub operations per class, bit n set when op n is assigned
	localparam logic [31:0] ADD_SUB_MAP = 32'hB0D7_CCF3;
	localparam logic [31:0] CMP_PICK_MAP = 32'h0030_DF7F;
	localparam logic [31:0] ABS_REPL_MAP = 32'hF802_3EFC;
	localparam logic [31:0] UNCHECKED_MAP = 32'hFFFF_FFFF;

	// unassigned add/subtract ops trap when set
	localparam logic ADD_SUB_UNASSIGNED_TRAPS = 1'b1;

	// decoded class
	typedef enum logic [3:0] {
		CLS_NONE        = 4'b0000,
		CLS_BRANCH_POS  = 4'b0001,
		CLS_INDEXED     = 4'b0010,
		CLS_INSERT_VAR  = 4'b0011,
		CLS_ADD_SUB     = 4'b0100,
		CLS_CMP_PICK    = 4'b0101,
		CLS_ABS_REPL    = 4'b0110,
		CLS_SHIFT       = 4'b0111,
		CLS_DOT_PROD    = 4'b1000,
		CLS_ACC_EXTRACT = 4'b1001,
		CLS_MOVE_TO     = 4'b1010,
		CLS_MOVE_FROM   = 4'b1011
	} cls_t;

	// decoded operation record
	typedef struct packed {
		cls_t       cls;        // operation class
		logic [4:0] sub_op;     // sub operation code
		logic [4:0] first_src;  // first source or base register
		logic [4:0] second_src; // second source or index register
		logic [4:0] dest;       // destination register
		logic [1:0] acc_sel;    // accumulator select
		logic [9:0] imm10;      // replicate immediate
		logic       indexed;    // first/second are base/index
	} dec_t;

	localparam dec_t DEC_RESET = '{cls: CLS_NONE, default: '0};

endpackage

// file: logic/sub_op_check.sv
// sub operation legality lookup for the classes that need a second decode step
`timescale 1ns/1ps
module sub_op_check
	import dsp_dec_pkg::*;
(
	input  wire dsp_dec_pkg::cls_t cls,     // class of the word
	input  wire logic [4:0]        sub_op,  // sub operation field
	output logic                   assigned // op is a named operation
);

	// legal op map for a class, unchecked classes pass
	function automatic logic [31:0] class_map(input cls_t c);
		unique case (c)
			CLS_ADD_SUB:  class_map = ADD_SUB_MAP;
			CLS_CMP_PICK: class_map = CMP_PICK_MAP;
			CLS_ABS_REPL: class_map = ABS_REPL_MAP;
			default:      class_map = UNCHECKED_MAP;
		endcase
	endfunction

	logic [31:0] op_map; // legal op map of this class

	// bit select by op code, map held in a variable since a call result cannot be indexed
	always_comb begin
		op_map = class_map(cls);
		assigned = op_map[sub_op];
	end

endmodule // sub_op_check

// file: logic/dsp_ext_decoder.sv
// instruction decoder for the signal-processing extension opcodes
`timescale 1ns/1ps
module dsp_ext_decoder #(
	parameter logic [5:0] MOVE_TO_FN   = 6'h00, // base-space function of moves into accumulator halves
	parameter logic [5:0] MOVE_FROM_FN = 6'h01  // base-space function of moves out of accumulator halves
) (
	input  wire logic               CLOCK,        // core clock
	input  wire logic               SYS_RST,      // synchronous reset, high
	input  wire logic               INSTR_VALID,  // instruction word present
	input  wire logic [31:0]        INSTR,        // instruction word
	input  wire logic               IMPL_RELEASE2, // core implements release 2
	output dsp_dec_pkg::dec_t       DEC,          // decoded operation
	output logic                    DEC_VALID,    // decoded record valid
	output logic                    RSVD_EXC      // reserved instruction exception
);
	import dsp_dec_pkg::*;

	logic [5:0] major;       // major opcode
	logic [2:0] major_row;   // major opcode row
	logic [2:0] major_col;   // major opcode column
	logic [5:0] func;        // function field
	logic [4:0] sub_op;      // op field
	logic [4:0] rt_field;    // second source field
	logic       op_ok;       // op legal in class
	dec_t       dec_d;       // next record
	logic       exc_d;       // next exception
	dec_t       dec_q;       // registered record
	logic       valid_q;     // registered valid
	logic       exc_q;       // registered exception
	cls_t       fn_cls;      // class from the function field alone

	// field extraction
	assign major_row = INSTR[MAJOR_HI -: 3];
	assign major_col = INSTR[MAJOR_LO +: 3];
	assign major = {major_row, major_col};
	assign func = INSTR[FUNC_HI:FUNC_LO];
	assign sub_op = INSTR[SUBOP_HI:SUBOP_LO];
	assign rt_field = INSTR[SECOND_HI:SECOND_LO];

	// class of an extended-space function code, none for blank or reserved slots
	function automatic cls_t ext_class(input logic [5:0] fn);
		unique case (fn)
			FN_INDEXED_LOAD: ext_class = CLS_INDEXED;
			FN_INSERT_VAR:   ext_class = CLS_INSERT_VAR;
			FN_ADD_SUB:      ext_class = CLS_ADD_SUB;
			FN_CMP_PICK:     ext_class = CLS_CMP_PICK;
			FN_ABS_REPL:     ext_class = CLS_ABS_REPL;
			FN_SHIFT:        ext_class = CLS_SHIFT;
			FN_DOT_PROD:     ext_class = CLS_DOT_PROD;
			FN_ACC_EXTRACT:  ext_class = CLS_ACC_EXTRACT;
			default:         ext_class = CLS_NONE;
		endcase
	endfunction

	// lookup class taken straight from the word, so the trap decision never feeds back into it
	assign fn_cls = (major == MAJOR_EXTENDED) ? ext_class(func) : CLS_NONE;

	// second-step op lookup
	sub_op_check u_check (
		.cls      (fn_cls),
		.sub_op   (sub_op),
		.assigned (op_ok)
	);

	// class decode and exception rules
	always_comb begin
		dec_d = DEC_RESET;
		exc_d = 1'b0;
		dec_d.sub_op = sub_op;
		dec_d.first_src = INSTR[FIRST_HI:FIRST_LO];
		dec_d.second_src = rt_field;
		dec_d.dest = INSTR[DEST_HI:DEST_LO];
		if (major == MAJOR_EXTENDED) begin
			unique case (func)
				FN_INDEXED_LOAD: begin
					dec_d.cls = CLS_INDEXED;
					dec_d.indexed = 1'b1;
				end
				FN_INSERT_VAR:  dec_d.cls = CLS_INSERT_VAR;
				FN_ADD_SUB:     dec_d.cls = CLS_ADD_SUB;
				FN_CMP_PICK:    dec_d.cls = CLS_CMP_PICK;
				FN_ABS_REPL:    dec_d.cls = CLS_ABS_REPL;
				FN_SHIFT:       dec_d.cls = CLS_SHIFT;
				FN_DOT_PROD: begin
					dec_d.cls = CLS_DOT_PROD;
					dec_d.acc_sel = INSTR[ACC_TO_LO +: 2];
				end
				FN_ACC_EXTRACT: begin
					dec_d.cls = CLS_ACC_EXTRACT;
					dec_d.acc_sel = INSTR[ACC_TO_LO +: 2];
				end
				default: begin
					// reserved and higher-level codes trap, blank slots belong elsewhere
					exc_d = FN_RESERVED_MAP[func];
				end
			endcase
			// unassigned op codes in the checked classes
			if (!op_ok) begin
				if (dec_d.cls == CLS_ADD_SUB) begin
					exc_d = ADD_SUB_UNASSIGNED_TRAPS;
				end else begin
					exc_d = 1'b1;
				end
			end
			// absolute/replicate operand forms
			if (dec_d.cls == CLS_ABS_REPL) begin
				if (sub_op == OP_ABS_HALF && dec_d.first_src != 5'h00) begin
					exc_d = 1'b1;
				end
				if (sub_op == OP_REPL_HALF) begin
					dec_d.imm10 = INSTR[FIRST_HI:SECOND_LO];
				end
			end
			// release 1 has no extended space at all
			if (!IMPL_RELEASE2) begin
				exc_d = 1'b1;
			end
		end else if (major == MAJOR_BRANCH) begin
			if (rt_field == RT_POS_GE_32) begin
				dec_d.cls = CLS_BRANCH_POS;
			end else if (rt_field == RT_POS_HIGHER) begin
				exc_d = 1'b1;
			end
		end else if (major == MAJOR_BASE_DEF) begin
			if (func == MOVE_TO_FN) begin
				dec_d.cls = CLS_MOVE_TO;
				dec_d.acc_sel = INSTR[ACC_TO_LO +: 2];
			end else if (func == MOVE_FROM_FN) begin
				dec_d.cls = CLS_MOVE_FROM;
				dec_d.acc_sel = INSTR[ACC_FROM_LO +: 2];
			end
		end
		// an exception carries no operation
		if (exc_d) begin
			dec_d.cls = CLS_NONE;
		end
	end

	// decoded record register
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			dec_q <= DEC_RESET;
		end else if (INSTR_VALID) begin
			dec_q <= dec_d;
		end
	end

	// valid register
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			valid_q <= 1'b0;
		end else begin
			valid_q <= INSTR_VALID;
		end
	end

	// exception register, only for a present word
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			exc_q <= 1'b0;
		end else begin
			exc_q <= INSTR_VALID & exc_d;
		end
	end

	assign DEC = dec_q;
	assign DEC_VALID = valid_q;
	assign RSVD_EXC = exc_q;

	// checks on the registered results
	a_ext_cmp_pick: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && IMPL_RELEASE2 && INSTR[31:26] == 6'h1F && INSTR[5:0] == 6'h11 && INSTR[10:6] == 5'h03)
		|=> (DEC.cls == CLS_CMP_PICK && !RSVD_EXC))
		else $error("compare/pick pick op not decoded");
	a_rel1_traps: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && !IMPL_RELEASE2 && INSTR[31:26] == 6'h1F) |=> RSVD_EXC && DEC.cls == CLS_NONE)
		else $error("release 1 extended word did not trap");
	a_branch_pos: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && INSTR[31:26] == 6'h01 && INSTR[20:16] == 5'h1C) |=> DEC.cls == CLS_BRANCH_POS && !RSVD_EXC)
		else $error("position branch not decoded");
	a_branch_higher: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && INSTR[31:26] == 6'h01 && INSTR[20:16] == 5'h1D) |=> RSVD_EXC)
		else $error("higher level branch did not trap");
	a_upper_reserved: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && INSTR[31:26] == 6'h1F && (INSTR[5:3] == 3'b011 || INSTR[5:3] == 3'b101)) |=> RSVD_EXC)
		else $error("reserved function row did not trap");
	a_higher_fn: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && INSTR[31:26] == 6'h1F && (INSTR[5:0] == 6'h0D || INSTR[5:2] == 4'b0101
		|| INSTR[5:0] == 6'h34 || INSTR[5:0] == 6'h3C)) |=> RSVD_EXC)
		else $error("higher level function did not trap");
	a_dot_acc: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && IMPL_RELEASE2 && INSTR[31:26] == 6'h1F && INSTR[5:0] == 6'h30)
		|=> DEC.acc_sel == $past(INSTR[12:11]) && DEC.cls == CLS_DOT_PROD)
		else $error("dot product accumulator wrong");
	a_repl_imm: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && IMPL_RELEASE2 && INSTR[31:26] == 6'h1F && INSTR[5:0] == 6'h12 && INSTR[10:6] == 5'h0A)
		|=> DEC.imm10 == $past(INSTR[25:16]) && DEC.dest == $past(INSTR[15:11]) && !RSVD_EXC)
		else $error("replicate immediate wrong");
	a_abs_nonzero: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && INSTR[31:26] == 6'h1F && INSTR[5:0] == 6'h12 && INSTR[10:6] == 5'h09
		&& INSTR[25:21] != 5'h00) |=> RSVD_EXC)
		else $error("absolute with nonzero first field did not trap");
	a_cmp_reserved: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && INSTR[31:26] == 6'h1F && INSTR[5:0] == 6'h11 && INSTR[10:9] == 2'b11) |=> RSVD_EXC)
		else $error("reserved compare op did not trap");
	a_add_named: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && IMPL_RELEASE2 && INSTR[31:26] == 6'h1F && INSTR[5:0] == 6'h10 && INSTR[10:6] == 5'h12)
		|=> DEC.cls == CLS_ADD_SUB && DEC.sub_op == 5'h12 && !RSVD_EXC)
		else $error("modulo subtract not decoded");
	a_indexed_fields: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && IMPL_RELEASE2 && INSTR[31:26] == 6'h1F && INSTR[5:0] == 6'h0A)
		|=> DEC.indexed && DEC.first_src == $past(INSTR[25:21]) && DEC.second_src == $past(INSTR[20:16]))
		else $error("indexed load fields wrong");
	a_exc_needs_word: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		!INSTR_VALID |=> !RSVD_EXC && !DEC_VALID)
		else $error("exception without a word");
	a_insert_var: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && IMPL_RELEASE2 && INSTR[31:26] == 6'h1F && INSTR[5:0] == 6'h0C)
		|=> DEC.cls == CLS_INSERT_VAR && !RSVD_EXC)
		else $error("insert variable not decoded");
	a_add_unassigned: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && IMPL_RELEASE2 && INSTR[31:26] == 6'h1F && INSTR[5:0] == 6'h10
		&& INSTR[10:6] inside {5'h02, 5'h03, 5'h08, 5'h09, 5'h0C, 5'h0D, 5'h13,
		5'h15, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1E})
		|=> RSVD_EXC == ADD_SUB_UNASSIGNED_TRAPS)
		else $error("unassigned add/subtract op wrong");
	a_move_from: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && INSTR[31:26] == MAJOR_BASE_DEF && INSTR[5:0] == MOVE_FROM_FN)
		|=> DEC.cls == CLS_MOVE_FROM && DEC.acc_sel == $past(INSTR[22:21]))
		else $error("move from accumulator select wrong");
	a_blank_slot: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(INSTR_VALID && IMPL_RELEASE2 && INSTR[31:26] == 6'h1F
		&& (INSTR[5:3] == 3'b000 || INSTR[5:0] inside {6'h08, 6'h09, 6'h20, 6'h24, 6'h3B}))
		|=> DEC.cls == CLS_NONE && !RSVD_EXC)
		else $error("blank extended slot trapped");
	a_valid_pulse: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		INSTR_VALID |=> DEC_VALID)
		else $error("word without an answer");
	a_field_copy: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		INSTR_VALID |=> DEC.sub_op == $past(INSTR[10:6]) && DEC.first_src == $past(INSTR[25:21])
		&& DEC.dest == $past(INSTR[15:11]))
		else $error("operand fields not passed through");

endmodule // dsp_ext_decoder

// file: tb/issue_stage_model.sv
// behavioural model of the fetch and issue stage that feeds the decoder
`timescale 1ns/1ps
module issue_stage_model (
	input  wire logic        clock,       // core clock
	output logic             instr_valid, // word present
	output logic [31:0]      instr        // instruction word
);
	logic [31:0] last_word; // last word handed over

	// idle at time zero
	initial begin
		instr_valid = 1'b0;
		instr = 32'h0000_0000;
		last_word = 32'h0000_0000;
	end

	// present one word just after the next rising edge, held until the next put or drop
	task automatic put(input logic [31:0] word);
		@(posedge clock);
		#1;
		instr_valid = 1'b1;
		instr = word;
		last_word = word;
	endtask

	// released bus shows the inverse of the last word, never a stale match
	task automatic drop();
		@(posedge clock);
		#1;
		instr_valid = 1'b0;
		instr = ~last_word;
	endtask
endmodule // issue_stage_model

// file: tb/tb_top.sv
// self-checking bench for the extension opcode decoder
`timescale 1ns/1ps
module tb_top;
	import dsp_dec_pkg::*;
	localparam logic [5:0] MV_TO = 6'h00;   // base function, move into halves
	localparam logic [5:0] MV_FROM = 6'h01; // base function, move out of halves
	logic        clk;         // core clock
	logic        rst;         // synchronous reset
	logic        rel2;        // release 2 core
	logic        instr_valid; // word present
	logic [31:0] instr;       // word
	dec_t        dec;         // decoded record
	logic        dec_valid;   // answer pulse
	logic        rsvd_exc;    // trap request
	int          errors;      // mismatches
	int          n_compared;  // comparisons
	logic [31:0] wq[$];       // words awaiting answer
	cls_t        cq[$];       // expected classes
	logic        tq[$];       // expected traps

	issue_stage_model fetch (.clock(clk), .instr_valid(instr_valid), .instr(instr));
	dsp_ext_decoder #(.MOVE_TO_FN(MV_TO), .MOVE_FROM_FN(MV_FROM)) uut (.CLOCK(clk), .SYS_RST(rst),
		.INSTR_VALID(instr_valid), .INSTR(instr), .IMPL_RELEASE2(rel2), .DEC(dec), .DEC_VALID(dec_valid),
		.RSVD_EXC(rsvd_exc));

	// free running clock, 4 ns
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// compare and count
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] mk(input logic [5:0] maj, input logic [4:0] rs, input logic [4:0] rt,
		input logic [4:0] rd, input logic [4:0] op, input logic [5:0] fn);
		return {maj, rs, rt, rd, op, fn};
	endfunction

	// extended space word with fixed second source and destination
	function automatic logic [31:0] ext(input logic [4:0] rs, input logic [4:0] op, input logic [5:0] fn);
		return mk(MAJOR_EXTENDED, rs, 5'h05, 5'h07, op, fn);
	endfunction

	// queue a word and its expected answer
	task automatic add(input logic [31:0] w, input cls_t c, input logic t);
		wq.push_back(w);
		cq.push_back(t ? CLS_NONE : c);
		tq.push_back(t);
	endtask

	// judge the answer to one word
	task automatic judge(input logic [31:0] w, input cls_t c, input logic t);
		check(dec_valid, 1'b1);
		check(rsvd_exc, t);
		check(dec.cls, c);
		if (w[31:26] == MAJOR_EXTENDED)
			check({dec.sub_op, dec.first_src, dec.second_src, dec.dest}, {w[10:6], w[25:21], w[20:16], w[15:11]});
		if (w[31:26] == MAJOR_EXTENDED && !t)
			check(dec.imm10, (c == CLS_ABS_REPL && w[10:6] == OP_REPL_HALF) ? w[25:16] : 10'h000);
		if (c inside {CLS_DOT_PROD, CLS_ACC_EXTRACT, CLS_MOVE_TO})
			check(dec.acc_sel, w[12:11]);
		if (c == CLS_MOVE_FROM)
			check(dec.acc_sel, w[22:21]);
		if (c == CLS_INDEXED)
			check(dec.indexed, 1'b1);
	endtask

	// issue queued words back to back, judging each one cycle later
	task automatic flush();
		int n;
		n = wq.size();
		for (int i = 0; i <= n; i++) begin
			if (i < n)
				fetch.put(wq[i]);
			else
				fetch.drop();
			if (i > 0)
				judge(wq[i-1], cq[i-1], tq[i-1]);
		end
		@(posedge clk);
		#1;
		check(dec_valid, 1'b0);
		check(rsvd_exc, 1'b0);
		check(dec.cls, cq[n-1]);
		wq.delete();
		cq.delete();
		tq.delete();
	endtask

	// function field classes, reserved and higher level codes
	task automatic t_functions();
		logic [5:0] bad[12] = '{6'h0D, 6'h14, 6'h17, 6'h34, 6'h3C, 6'h18, 6'h1F, 6'h28, 6'h2F, 6'h0B, 6'h0E, 6'h2C};
		add(ext(5'h03, 5'h00, FN_INDEXED_LOAD), CLS_INDEXED, 1'b0);
		add(ext(5'h03, 5'h00, FN_INSERT_VAR), CLS_INSERT_VAR, 1'b0);
		add(ext(5'h03, 5'h00, FN_ADD_SUB), CLS_ADD_SUB, 1'b0);
		add(ext(5'h03, 5'h00, FN_CMP_PICK), CLS_CMP_PICK, 1'b0);
		add(ext(5'h00, OP_ABS_HALF, FN_ABS_REPL), CLS_ABS_REPL, 1'b0);
		add(ext(5'h03, 5'h00, FN_SHIFT), CLS_SHIFT, 1'b0);
		add(ext(5'h03, 5'h03, FN_DOT_PROD), CLS_DOT_PROD, 1'b0);
		add(ext(5'h03, 5'h00, FN_ACC_EXTRACT), CLS_ACC_EXTRACT, 1'b0);
		add(ext(5'h03, 5'h00, 6'h20), CLS_NONE, 1'b0);
		add(ext(5'h03, 5'h00, 6'h05), CLS_NONE, 1'b0);
		add(ext(5'h03, 5'h00, 6'h3B), CLS_NONE, 1'b0);
		foreach (bad[i]) add(ext(5'h03, 5'h00, bad[i]), CLS_NONE, 1'b1);
		flush();
		$display("test functions done");
	endtask

	// position branch and its higher level neighbour
	task automatic t_branch();
		add(mk(MAJOR_BRANCH, 5'h04, RT_POS_GE_32, 5'h00, 5'h00, 6'h10), CLS_BRANCH_POS, 1'b0);
		add(mk(MAJOR_BRANCH, 5'h04, RT_POS_HIGHER, 5'h00, 5'h00, 6'h10), CLS_NONE, 1'b1);
		add(mk(MAJOR_BRANCH, 5'h04, 5'h00, 5'h00, 5'h00, 6'h10), CLS_NONE, 1'b0);
		flush();
		$display("test branch done");
	endtask

	// sub operation tables of the three checked classes
	task automatic t_subops();
		logic [4:0] as_ok[8] = '{5'h00, 5'h01, 5'h04, 5'h10, 5'h11, 5'h12, 5'h14, 5'h1F};
		logic [4:0] cp_ok[8] = '{5'h03, 5'h06, 5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h14, 5'h15};
		logic [4:0] as_bad[3] = '{5'h02, 5'h13, 5'h1E};
		logic [4:0] cp_bad[3] = '{5'h07, 5'h10, 5'h1F};
		foreach (as_ok[i]) add(ext(5'h03, as_ok[i], FN_ADD_SUB), CLS_ADD_SUB, 1'b0);
		foreach (cp_ok[i]) add(ext(5'h03, cp_ok[i], FN_CMP_PICK), CLS_CMP_PICK, 1'b0);
		foreach (as_bad[i]) add(ext(5'h03, as_bad[i], FN_ADD_SUB), CLS_ADD_SUB, ADD_SUB_UNASSIGNED_TRAPS);
		foreach (cp_bad[i]) add(ext(5'h03, cp_bad[i], FN_CMP_PICK), CLS_CMP_PICK, 1'b1);
		add(ext(5'h01, OP_ABS_HALF, FN_ABS_REPL), CLS_ABS_REPL, 1'b1);
		add(ext(5'h15, OP_REPL_HALF, FN_ABS_REPL), CLS_ABS_REPL, 1'b0);
		add(ext(5'h03, 5'h00, FN_ABS_REPL), CLS_ABS_REPL, 1'b1);
		flush();
		$display("test subops done");
	endtask

	// indexed operands and every accumulator number
	task automatic t_accum();
		add(ext(5'h03, 5'h00, FN_INDEXED_LOAD), CLS_INDEXED, 1'b0);
		for (int a = 0; a < 4; a++) begin
			add(mk(MAJOR_EXTENDED, 5'h03, 5'h05, {3'h0, a[1:0]}, 5'h03, FN_DOT_PROD), CLS_DOT_PROD, 1'b0);
			add(mk(MAJOR_EXTENDED, 5'h03, 5'h05, {3'h0, a[1:0]}, 5'h00, FN_ACC_EXTRACT), CLS_ACC_EXTRACT, 1'b0);
			add(mk(MAJOR_BASE_DEF, 5'h02, 5'h00, {3'h0, a[1:0]}, 5'h00, MV_TO), CLS_MOVE_TO, 1'b0);
			add(mk(MAJOR_BASE_DEF, {3'h0, a[1:0]}, 5'h00, 5'h02, 5'h00, MV_FROM), CLS_MOVE_FROM, 1'b0);
		end
		flush();
		$display("test accum done");
	endtask

	// release 1 core traps the whole extended space, words spaced out
	task automatic t_release1();
		logic [5:0] fns[4] = '{FN_ADD_SUB, FN_INDEXED_LOAD, 6'h20, FN_DOT_PROD};
		rel2 = 1'b0;
		foreach (fns[i]) begin
			add(ext(5'h03, 5'h00, fns[i]), CLS_NONE, 1'b1);
			flush();
		end
		add(mk(MAJOR_BRANCH, 5'h04, RT_POS_GE_32, 5'h00, 5'h00, 6'h10), CLS_BRANCH_POS, 1'b0);
		flush();
		rel2 = 1'b1;
		$display("test release1 done");
	endtask

	// reset in mid run clears a held record and swallows a trapping word
	task automatic t_reset();
		check(dec.cls, CLS_BRANCH_POS);
		rst = 1'b1;
		fetch.put(ext(5'h03, 5'h00, 6'h0D));
		fetch.drop();
		check(dec_valid, 1'b0);
		check(rsvd_exc, 1'b0);
		check(dec, DEC_RESET);
		rst = 1'b0;
		@(posedge clk);
		#1;
		check(dec_valid, 1'b0);
		check(dec, DEC_RESET);
		fetch.put(ext(5'h03, 5'h00, 6'h0D));
		fetch.drop();
		judge(ext(5'h03, 5'h00, 6'h0D), CLS_NONE, 1'b1);
		$display("test reset done");
	endtask

	// counts, verdict and end of run
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// main sequence
	initial begin
		errors = 0;
		n_compared = 0;
		rel2 = 1'b1;
		rst = 1'b1;
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		@(posedge clk);
		#1;
		check(dec_valid, 1'b0);
		check(rsvd_exc, 1'b0);
		check(dec, DEC_RESET);
		t_functions();
		t_branch();
		t_subops();
		t_accum();
		t_release1();
		t_reset();
		report_and_stop();
	end

	// watchdog, far beyond the roughly 113 cycles the tests need
	initial begin
		#8000;
		errors++;
		report_and_stop();
	end
endmodule // tb_top
